// ### hfx_osc_ctrl.sv
// Register set and startup sequencer of the crystal oscillator controller.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns

// ****************************************************************
// Top module
// ****************************************************************
// Overview of operation
// [RULE1] Auto bit starts and selects oscillator in active modes, stalling source clock.
// [RULE2] Mode 0 runs peak detection on first startup; command accepted once ready.
// [RULE3] Mode 2 runs peak detection only on command; mode 1 also accepts it.
// [RULE4] Mode 3 hands steady bias and detector enable to software once ready.
// [RULE5] Source field takes effect only when the enable command is written; the code also latches it on an auto start.
// [RULE6] Source codes: crystal, AC buffer, DC buffer, digital clock on negative pin.
// [RULE7] Threshold codes 0 to 6 select levels; code 7 acts as 6.
// [RULE8] Software leaves the threshold alone while detection or monitoring runs.
// [RULE9] Startup tuning capacitance applies during startup phase.
// [RULE10] Startup core bias applies during startup phase.
// [RULE11] Peak monitor steps on each rising edge of the low-rate clock.
// [RULE12] Detector enable drives detectors directly in manual mode after ready.
// [RULE13] Steady core bias applies after startup and seeds peak detection; outside mode 3 the code drives the last peak detection bias instead.
// [RULE14] Startup wait field picks the wait count from the shared ladder.
// [RULE15] Reserved bits are written as zero and read as zero.
module hfx_osc_ctrl #(
	parameter logic [17:0] WAIT_LIMIT = 18'h20000
) (
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// AXI4-Lite write address and data
	input  wire logic [11:0]            awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	// AXI4-Lite write response
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	// AXI4-Lite read
	input  wire logic [11:0]            araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	// System and analog inputs
	input  wire logic                   active_mode,
	input  wire logic                   ultra_low_rc_clock,
	input  wire logic                   amp_above,
	// Oscillator controls
	output hfx_pkg::hfx_osc_ctrl_s      osc
);
	import hfx_pkg::*;

	typedef enum logic [1:0] {
		S_OFF,
		S_STARTUP,
		S_PEAKDET,
		S_READY
	} hfx_seq_e;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] thr;
		logic [31:0] start;
		logic [31:0] steady;
		logic [31:0] waits;
		hfx_source_e run_src;
		hfx_seq_e    seq;
		logic        first_done;
		logic        pkd_done;
		logic        rc_prev;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		hfx_osc_ctrl_s osc;
	} hfx_top_s;

	hfx_top_s st;
	hfx_top_s next_st;

	logic        wr_go;
	logic        rd_go;
	logic        cmd_en;
	logic        cmd_dis;
	logic        cmd_pkd;
	logic        auto_on;
	logic        tmr_start;
	logic        tmr_done;
	logic        pk_start;
	logic        pk_busy;
	logic        pk_done;
	logic        mon_tick;
	logic [10:0] pk_bias;
	logic [1:0]  pmode;
	logic        ready;

	// Merge written bytes into a register, keeping reserved bits at zero.
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] be,
			input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		merge = res & mask; // RULE15
	endfunction

	// Decode whether an address hits a mapped register.
	function automatic logic mapped(input logic [11:0] a);
		case (a)
			OFS_CTRL, OFS_THR, OFS_START, OFS_STEADY, OFS_WAIT,
			OFS_CMD, OFS_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// ****************************************************************
	// Bus handshake
	// ****************************************************************
	// Write address and data are taken together once no response waits.
	assign awready = awvalid && wvalid && !st.bvalid;
	assign wready = awready;
	assign wr_go = awready;
	assign arready = !st.rvalid;
	assign rd_go = arvalid && arready;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;

	// Command strobes of the command register.
	assign cmd_en = wr_go && awaddr == OFS_CMD && wstrb[0] && wdata[B_CMD_EN];
	assign cmd_dis = wr_go && awaddr == OFS_CMD && wstrb[0] &&
		wdata[B_CMD_DIS];
	assign cmd_pkd = wr_go && awaddr == OFS_CMD && wstrb[0] &&
		wdata[B_CMD_PKD];

	assign pmode = st.ctrl[5:4];
	assign auto_on = st.ctrl[B_AUTO_SEL] && active_mode;
	assign ready = st.seq == S_READY || st.seq == S_PEAKDET;
	assign mon_tick = ultra_low_rc_clock && !st.rc_prev &&
		st.steady[B_MON_EN] && st.seq == S_READY && pmode != PKD_MANUAL;

	// Sequencer transition requests toward the helpers.
	assign tmr_start = st.seq == S_OFF && (cmd_en || auto_on);
	assign pk_start = (st.seq == S_STARTUP && tmr_done &&
		pmode != PKD_CMD && pmode != PKD_MANUAL &&
		!(pmode == PKD_ONCE && st.first_done)) ||
		(st.seq == S_READY && cmd_pkd && pmode != PKD_MANUAL);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	hfx_wait_timer #(
		.LIMIT (WAIT_LIMIT)
	) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (tmr_start),
		.code    (st.waits[3:0]),
		.busy    (),
		.done    (tmr_done)
	);

	hfx_peak_tune u_peak (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.start     (pk_start),
		.mon_tick  (mon_tick),
		.init_bias (st.steady[10:0]),
		.amp_above (amp_above),
		.bias      (pk_bias),
		.busy      (pk_busy),
		.done      (pk_done)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Registers, sequencer and oscillator controls.
	always_comb begin
		next_st = st;
		next_st.rc_prev = ultra_low_rc_clock;

		// Register writes and write response.
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		if (wr_go) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
			case (awaddr)
				OFS_CTRL: next_st.ctrl = merge(st.ctrl, wdata, wstrb,
					MASK_CTRL); // RULE5
				OFS_THR: next_st.thr = merge(st.thr, wdata, wstrb, MASK_THR);
				OFS_START: next_st.start = merge(st.start, wdata, wstrb,
					MASK_START);
				OFS_STEADY: next_st.steady = merge(st.steady, wdata, wstrb,
					MASK_STEADY);
				OFS_WAIT: next_st.waits = merge(st.waits, wdata, wstrb,
					MASK_WAIT);
				default: next_st.bresp = next_st.bresp;
			endcase
		end

		// Register reads.
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
		if (rd_go) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			case (araddr)
				OFS_CTRL: next_st.rdata = st.ctrl;
				OFS_THR: next_st.rdata = st.thr;
				OFS_START: next_st.rdata = st.start;
				OFS_STEADY: next_st.rdata = st.steady;
				OFS_WAIT: next_st.rdata = st.waits;
				OFS_STATUS: next_st.rdata = {28'h0000000, st.osc.selected,
					st.pkd_done, st.seq != S_OFF, ready};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end

		// Sequencer.
		case (st.seq)
			S_OFF: begin
				if (tmr_start) begin
					// Source is latched on the enable command or on an auto start.
					next_st.run_src = hfx_source_e'(st.ctrl[1:0]); // RULE5
					next_st.seq = S_STARTUP;
				end
			end
			S_STARTUP: begin
				if (tmr_done) begin
					next_st.first_done = 1'b1;
					next_st.seq = pk_start ? S_PEAKDET : S_READY; // RULE2
				end
			end
			S_PEAKDET: begin
				if (pk_done) begin
					next_st.seq = S_READY;
				end
			end
			S_READY: begin
				if (pk_start) begin
					next_st.seq = S_PEAKDET; // RULE3
				end
			end
			default: next_st.seq = S_OFF;
		endcase
		if (cmd_dis && !auto_on) begin
			next_st.seq = S_OFF;
		end

		// Done flag: a new start clears it, completion sets it and wins.
		if (pk_start) begin
			next_st.pkd_done = 1'b0;
		end
		if (pk_done) begin
			next_st.pkd_done = 1'b1;
		end

		// Oscillator controls for the next cycle.
		next_st.osc.enable = next_st.seq != S_OFF;
		next_st.osc.source = next_st.run_src; // RULE6
		next_st.osc.startup = next_st.seq == S_STARTUP;
		if (next_st.seq == S_STARTUP || next_st.seq == S_OFF) begin
			next_st.osc.core_bias = next_st.start[10:0]; // RULE10
			next_st.osc.tuning_cap = next_st.start[19:11]; // RULE9
		end else begin
			next_st.osc.tuning_cap = next_st.steady[19:11];
			if (next_st.ctrl[5:4] == PKD_MANUAL) begin
				next_st.osc.core_bias = next_st.steady[10:0]; // RULE4
			end else begin
				next_st.osc.core_bias = pk_bias; // RULE13
			end
		end
		next_st.osc.threshold = (next_st.thr[14:12] > THR_TOP) ?
			THR_TOP : next_st.thr[14:12]; // RULE7
		if (next_st.ctrl[5:4] == PKD_MANUAL) begin
			next_st.osc.detector_on = next_st.steady[B_PKD_EN] &&
				(next_st.seq == S_READY); // RULE12
		end else begin
			next_st.osc.detector_on = next_st.seq == S_PEAKDET;
		end
		next_st.osc.selected = next_st.ctrl[B_AUTO_SEL] && active_mode;
		next_st.osc.stall = next_st.ctrl[B_AUTO_SEL] && active_mode &&
			next_st.seq != S_READY && next_st.seq != S_PEAKDET; // RULE1
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// All state of the block, with documented reset values.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.ctrl <= RST_CTRL;
			st.thr <= RST_THR;
			st.start <= RST_START;
			st.steady <= RST_STEADY;
			st.waits <= RST_WAIT;
			st.seq <= S_OFF;
			st.osc.core_bias <= RST_START[10:0];
			st.osc.threshold <= RST_THR[14:12];
		end else begin
			st <= next_st;
		end
	end

	assign osc = st.osc;

	// ****************************************************************
	// Checks
	// ****************************************************************
	// Stall is registered together with the sequencer state, so it is
	// compared in the same cycle; a next-cycle check would trip on the
	// last startup cycle, where the state is already leaving startup.
	a_auto_stall: assert property (@(posedge aclk) disable iff (!aresetn)
		st.ctrl[B_AUTO_SEL] && active_mode && !ready && $stable(active_mode)
		|-> osc.stall) // RULE1
		else $error("source clock not stalled before ready");
	a_once_skip: assert property (@(posedge aclk) disable iff (!aresetn)
		st.seq == S_STARTUP && tmr_done && pmode == PKD_ONCE && st.first_done
		|=> st.seq == S_READY) // RULE2
		else $error("peak detection repeated in once mode");
	a_cmd_peak: assert property (@(posedge aclk) disable iff (!aresetn)
		st.seq == S_READY && cmd_pkd && pmode == PKD_CMD && !cmd_dis
		|=> st.seq == S_PEAKDET ##1 osc.detector_on) // RULE3
		else $error("peak start command not taken");
	a_manual_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		st.seq == S_READY && pmode == PKD_MANUAL && !cmd_dis |=>
		st.seq == S_READY) // RULE4
		else $error("manual mode left ready state");
	a_src_latch: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(st.run_src) |-> $past(tmr_start)) // RULE5
		else $error("running source changed without enable");
	a_thr_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
		st.thr[14:12] == 3'h7 && $stable(st.thr) |-> osc.threshold == THR_TOP)
		else $error("threshold code seven not clamped"); // RULE7
	a_startup_trim: assert property (@(posedge aclk) disable iff (!aresetn)
		osc.startup && $stable(st.start) |-> osc.core_bias == st.start[10:0]
		&& osc.tuning_cap == st.start[19:11]) // RULE9
		else $error("startup trims not applied");
	a_manual_bias: assert property (@(posedge aclk) disable iff (!aresetn)
		st.seq == S_READY && $stable(st.seq) && $stable(st.steady) &&
		$stable(st.ctrl) && pmode == PKD_MANUAL |->
		osc.core_bias == st.steady[10:0]) // RULE13
		else $error("steady bias not applied");
	a_bus_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_go |=> rvalid)
		else $error("read not answered next cycle");

	c_peak_run: cover property (@(posedge aclk) disable iff (!aresetn)
		st.seq == S_PEAKDET ##1 st.seq == S_READY);
	c_auto_start: cover property (@(posedge aclk) disable iff (!aresetn)
		osc.stall ##1 !osc.stall && osc.selected);
	c_manual_ready: cover property (@(posedge aclk) disable iff (!aresetn)
		st.seq == S_READY && pmode == PKD_MANUAL && osc.detector_on);
	c_monitor: cover property (@(posedge aclk) disable iff (!aresetn)
		mon_tick);
endmodule

// ### hfx_pkg.sv
// Constants, field layouts and carrier types of the crystal oscillator control.
package hfx_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] OFS_CTRL = 12'h024;
	localparam logic [11:0] OFS_THR = 12'h028;
	localparam logic [11:0] OFS_START = 12'h02c;
	localparam logic [11:0] OFS_STEADY = 12'h030;
	localparam logic [11:0] OFS_WAIT = 12'h034;
	localparam logic [11:0] OFS_CMD = 12'h060;
	localparam logic [11:0] OFS_STATUS = 12'h064;

	// Writable bit masks; all other bits are reserved and read as zero.
	localparam logic [31:0] MASK_CTRL = 32'h2000_0033;
	localparam logic [31:0] MASK_THR = 32'h0000_7000;
	localparam logic [31:0] MASK_START = 32'h000f_ffff;
	localparam logic [31:0] MASK_STEADY = 32'h0c0f_ffff;
	localparam logic [31:0] MASK_WAIT = 32'h0000_f0ff;

	// Reset values.
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_THR = 32'h0000_2000;
	localparam logic [31:0] RST_START = 32'h0000_0600;
	localparam logic [31:0] RST_STEADY = 32'h0800_0100;
	localparam logic [31:0] RST_WAIT = 32'h0000_d08e;

	// Field positions.
	localparam int unsigned B_AUTO_SEL = 29;
	localparam int unsigned B_MON_EN = 27;
	localparam int unsigned B_PKD_EN = 26;
	localparam int unsigned B_CMD_EN = 0;
	localparam int unsigned B_CMD_DIS = 1;
	localparam int unsigned B_CMD_PKD = 2;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Bias limits, threshold clamp and peak detection modes.
	localparam logic [10:0] BIAS_MAX = 11'h7ff;
	localparam logic [10:0] BIAS_MIN = 11'h000;
	localparam logic [2:0] THR_TOP = 3'h6;
	localparam logic [1:0] PKD_ONCE = 2'h0;
	localparam logic [1:0] PKD_AUTO = 2'h1;
	localparam logic [1:0] PKD_CMD = 2'h2;
	localparam logic [1:0] PKD_MANUAL = 2'h3;

	// External source selection.
	typedef enum logic [1:0] {
		SRC_CRYSTAL = 2'h0,
		SRC_AC_BUFFER = 2'h1,
		SRC_DC_BUFFER = 2'h2,
		SRC_DIGITAL = 2'h3
	} hfx_source_e;

	// Controls driven toward the analog oscillator.
	typedef struct packed {
		logic        enable;
		hfx_source_e source;
		logic        startup;
		logic [10:0] core_bias;
		logic [8:0]  tuning_cap;
		logic [2:0]  threshold;
		logic        detector_on;
		logic        selected;
		logic        stall;
	} hfx_osc_ctrl_s;

	// Wait ladder read by the startup wait field, bits 3:0 of the wait register.
	function automatic logic [17:0] hfx_wait_cycles(input logic [3:0] code);
		case (code)
			4'h0: hfx_wait_cycles = 18'h00002;
			4'h1: hfx_wait_cycles = 18'h00004;
			4'h2: hfx_wait_cycles = 18'h00010;
			4'h3: hfx_wait_cycles = 18'h00020;
			4'h4: hfx_wait_cycles = 18'h00040;
			4'h5: hfx_wait_cycles = 18'h00080;
			4'h6: hfx_wait_cycles = 18'h00100;
			4'h7: hfx_wait_cycles = 18'h00400;
			4'h8: hfx_wait_cycles = 18'h00800;
			4'h9: hfx_wait_cycles = 18'h01000;
			4'ha: hfx_wait_cycles = 18'h02000;
			4'hb: hfx_wait_cycles = 18'h04000;
			4'hc: hfx_wait_cycles = 18'h08000;
			4'hd: hfx_wait_cycles = 18'h10000;
			default: hfx_wait_cycles = 18'h20000;
		endcase
	endfunction

endpackage

// ### hfx_wait_timer.sv
// Wait timer that counts one ladder step of the startup wait.
`timescale 1ns/1ns
module hfx_wait_timer #(
	parameter logic [17:0] LIMIT = 18'h20000
) (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Control
	input  wire logic       start,
	input  wire logic [3:0] code,
	// Result
	output logic            busy,
	output logic            done
);
	import hfx_pkg::*;

	typedef struct packed {
		logic [17:0] cnt;
		logic        busy;
	} hfx_tmr_s;

	hfx_tmr_s st;
	hfx_tmr_s next_st;
	logic [17:0] len;

	// Load the ladder length, clamped by the limit, and count down.
	always_comb begin
		len = (hfx_wait_cycles(code) < LIMIT) ? hfx_wait_cycles(code) : LIMIT;
		next_st = st;
		if (start) begin
			next_st.cnt = len - 18'h00001; // RULE14
			next_st.busy = 1'b1;
		end else if (st.busy) begin
			if (st.cnt == 18'h00000) begin
				next_st.busy = 1'b0;
			end else begin
				next_st.cnt = st.cnt - 18'h00001;
			end
		end
	end

	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign busy = st.busy;
	assign done = st.busy && (st.cnt == 18'h00000) && !start;

	// Shortest step ends exactly two cycles after the start.
	a_wait_short: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
		start && code == 4'h0 |-> ##2 done)
		else $error("wait timer step length wrong");
endmodule

// ### hfx_peak_tune.sv
// Peak detection sequence and peak monitor that trim the core bias.
`timescale 1ns/1ns
module hfx_peak_tune (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Control
	input  wire logic        start,
	input  wire logic        mon_tick,
	input  wire logic [10:0] init_bias,
	// Analog comparator
	input  wire logic        amp_above,
	// Result
	output logic [10:0]      bias,
	output logic             busy,
	output logic             done
);
	import hfx_pkg::*;

	typedef struct packed {
		logic [10:0] bias;
		logic        busy;
		logic        done;
	} hfx_pk_s;

	hfx_pk_s st;
	hfx_pk_s next_st;

	// Sequence raises bias until the amplitude clears the threshold.
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (start) begin
			next_st.bias = init_bias; // RULE13
			next_st.busy = 1'b1;
		end else if (st.busy) begin
			if (amp_above || st.bias == BIAS_MAX) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end else begin
				next_st.bias = st.bias + 11'h001;
			end
		end else if (mon_tick) begin
			// Monitor takes one trim step per rising low-rate clock edge.
			if (amp_above && st.bias != BIAS_MIN) begin // RULE11
				next_st.bias = st.bias - 11'h001;
			end else if (!amp_above && st.bias != BIAS_MAX) begin
				next_st.bias = st.bias + 11'h001;
			end
		end
	end

	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bias = st.bias;
	assign busy = st.busy;
	assign done = st.done;

	a_mon_step_up: assert property (@(posedge aclk) disable iff (!aresetn)
		mon_tick && !start && !st.busy && !amp_above && st.bias != BIAS_MAX
		|=> bias == $past(bias) + 11'h001) // RULE11
		else $error("monitor did not raise bias");
	a_seq_loads: assert property (@(posedge aclk) disable iff (!aresetn)
		start |=> busy && bias == $past(init_bias)) // RULE13
		else $error("sequence did not load steady bias");
endmodule

// ### hfx_xtal_model.sv
// Behavioural crystal that shows amplitude once the core bias is high enough.
`timescale 1ns/1ns
module hfx_xtal_model
	import hfx_pkg::*;
#(
	parameter logic [10:0] SWING_BIAS = 11'h104
) (
	// Oscillator controls
	input  hfx_pkg::hfx_osc_ctrl_s osc,
	// Comparator result
	output logic                   amp_above
);
	// No swing while off or starting, so an early detector never sees a peak.
	always_comb begin
		amp_above = osc.enable && !osc.startup && (osc.core_bias >= SWING_BIAS);
	end
endmodule

// ### hfx_osc_ctrl_bench.sv
// Self-checking bench for the crystal oscillator controller.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module hfx_osc_ctrl_bench;
	import hfx_pkg::*;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] e;
		logic [31:0] v;
		logic [1:0]  r;
	} hfx_row_s;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic          aclk, aresetn, awvalid, wvalid, bvalid, bready, awready;
	logic          wready, arvalid, arready, rvalid, rready, act, ulrc, amp;
	logic [11:0]   awaddr, araddr;
	logic [31:0]   wdata, rdata, rd;
	logic [1:0]    bresp, rresp, rs;
	hfx_osc_ctrl_s osc;
	int            n_errors, num_checks, cyc, n;
	// Address, readback of all ones, reset value, response.
	hfx_row_s rows [6] = '{
		'{12'h024, 32'h2000_0033, 32'h0000_0000, 2'h0},
		'{12'h028, 32'h0000_7000, 32'h0000_2000, 2'h0},
		'{12'h02c, 32'h000f_ffff, 32'h0000_0600, 2'h0},
		'{12'h030, 32'h0c0f_ffff, 32'h0800_0100, 2'h0},
		'{12'h034, 32'h0000_f0ff, 32'h0000_d08e, 2'h0},
		'{12'h0f0, 32'h0000_0000, 32'h0000_0000, 2'h2}};
	// Short wait clamp keeps the reset wait code cheap to simulate.
	hfx_osc_ctrl #(.WAIT_LIMIT(18'h00040)) u_dut (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.active_mode(act), .ultra_low_rc_clock(ulrc), .amp_above(amp),
		.osc(osc));
	hfx_xtal_model u_xtal (.osc(osc), .amp_above(amp));
	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	// Write one word; both channels offered together, released when taken.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		#1;
		while (awready !== 1'b1) @(posedge aclk) #1;
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		#1;
		while (bvalid !== 1'b1) @(posedge aclk) #1;
		rs = bresp;
		@(posedge aclk);
		bready <= 1'b0;
		#1;
	endtask
	// Read one word and keep its data and response.
	task automatic rdr(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		#1;
		while (arready !== 1'b1) @(posedge aclk) #1;
		@(posedge aclk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		#1;
		while (rvalid !== 1'b1) @(posedge aclk) #1;
		rd = rdata;
		rs = rresp;
		@(posedge aclk);
		rready <= 1'b0;
		#1;
	endtask
	// Print the counts and the verdict, then stop.
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ****************************************************************
	// Clock, timeout and sequence
	// ****************************************************************
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// A hang past the expected run length counts as a mismatch.
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 6000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, act, ulrc} = '0;
		{awaddr, araddr, wdata} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// Reserved bits read zero; unmapped place answers an error.
		for (int i = 0; i < 6; i++) begin
			wr(rows[i].a, 32'hffff_ffff);
			`CHK("bresp", rows[i].r, rs)
			rdr(rows[i].a);
			`CHK("rdata", rows[i].e, rd)
			`CHK("rresp", rows[i].r, rs)
		end
		// Second reset restores the documented values.
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdr(rows[i].a);
			`CHK("reset value", rows[i].v, rd)
		end
		`CHK("reset bias", 11'h600, osc.core_bias)
		`CHK("reset thr", 3'h2, osc.threshold)
		// Threshold codes while the oscillator is off; code 7 acts as 6.
		for (int i = 0; i < 8; i++) begin
			wr(12'h028, {17'h0, 3'(i), 12'h0});
			@(posedge aclk) #1;
			`CHK("thr", (i == 7) ? 3'h6 : 3'(i), osc.threshold)
		end
		// Startup with DC buffer source and 16-cycle wait.
		wr(12'h02c, 32'h0005_5123);
		wr(12'h034, 32'h0000_d082);
		wr(12'h024, 32'h0000_0022);
		`CHK("src held", SRC_CRYSTAL, osc.source)
		wr(12'h060, 32'h0000_0001);
		`CHK("startup", 1'b1, osc.startup)
		`CHK("src", SRC_DC_BUFFER, osc.source)
		`CHK("start bias", 11'h123, osc.core_bias)
		`CHK("start cap", 9'h0aa, osc.tuning_cap)
		n = 0;
		while (osc.startup === 1'b1 && n < 100) begin
			n++;
			@(posedge aclk) #1;
		end
		`CHK("wait len", 16, n + 1)
		`CHK("steady cap", 9'h000, osc.tuning_cap)
		`CHK("no auto det", 1'b0, osc.detector_on)
		wr(12'h024, 32'h0000_0023);
		`CHK("src kept", SRC_DC_BUFFER, osc.source)
		// Commanded peak detection climbs from the steady bias.
		wr(12'h060, 32'h0000_0004);
		repeat (20) @(posedge aclk);
		rdr(12'h064);
		`CHK("pk done", 1'b1, rd[2])
		`CHK("pk bias", 1'b1, osc.core_bias inside {[11'h104:11'h105]})
		// Monitor steps the bias at each rising low-rate edge.
		for (int i = 0; i < 8; i++) begin
			repeat (3) @(posedge aclk);
			ulrc <= ~ulrc;
		end
		@(posedge aclk) #1;
		`CHK("mon bias", 1'b1, osc.core_bias inside {[11'h103:11'h104]})
		// Manual mode hands bias and detectors to software once ready.
		wr(12'h024, 32'h0000_0033);
		wr(12'h030, 32'h0400_01aa);
		@(posedge aclk) #1;
		`CHK("man det", 1'b1, osc.detector_on)
		`CHK("man bias", 11'h1aa, osc.core_bias)
		// Auto start and select follows the active mode.
		wr(12'h060, 32'h0000_0002);
		wr(12'h034, 32'h0000_d080);
		wr(12'h024, 32'h2000_0012);
		`CHK("off", 1'b0, osc.enable)
		`CHK("unsel", 1'b0, osc.selected)
		@(posedge aclk);
		act <= 1'b1;
		repeat (2) @(posedge aclk) #1;
		`CHK("auto on", 1'b1, osc.enable)
		`CHK("sel", 1'b1, osc.selected)
		`CHK("stall", 1'b1, osc.stall)
		repeat (40) @(posedge aclk) #1;
		`CHK("unstall", 1'b0, osc.stall)
		@(posedge aclk);
		act <= 1'b0;
		repeat (2) @(posedge aclk) #1;
		`CHK("desel", 1'b0, osc.selected)
		// Once mode skips detection on a later startup: ready right after
		// the two-cycle wait, with the detectors left off.
		wr(12'h060, 32'h0000_0002);
		wr(12'h024, 32'h2000_0002);
		@(posedge aclk);
		act <= 1'b1;
		repeat (3) @(posedge aclk) #1;
		`CHK("once on", 1'b1, osc.enable)
		`CHK("once unstall", 1'b0, osc.stall)
		`CHK("once skip", 1'b0, osc.detector_on)
		end_sim();
	end
endmodule
